// ===== design/fbev_defs.vh
// Constants for the flash block erase-verify host controller.
// Assumes a 25 MHz core clock and a device reached over a byte-wide bus.
// What this block does
// (RQ1) Every selected byte is programmed to 0x00 before erase starts.
// (RQ2) Software picks blocks through two erase block select registers.
// (RQ3) Erase enable set applies erase for as long as it stays set.
// (RQ4) Erase is split into timed pulses; total stays below thirty seconds.
// (RQ5) Watchdog is armed before erase mode is selected.
// (RQ6) After a pulse, erase enable cleared first, then erase verify bit set.
// (RQ7) Before each verify read, dummy byte 0xFF is written to that address.
// (RQ8) Dummy write latches address, applies verify; a read returns its data.
// (RQ9) Wait at least 2 us after a dummy write before reading.
// (RQ10) Wait at least 4 us after setting verify before first dummy write.
// (RQ11) An erased byte moves verify on to the next address.
// (RQ12) A failed byte re-enters erase and repeats until every byte is ones.
// (RQ13) Abandon after 602 combined erase and verify cycles.
// (RQ14) Prewrite: at most six program cycles per bit, within 1 ms total; the first pulse, pgm_cyc_ff cycles long, is not checked against 1 ms.
// (RQ15) Erase stops when enable clears and never acts with verify set.
`ifndef FBEV_DEFS_VH
`define FBEV_DEFS_VH
`define FBEV_A_MODE 16'hff80
`define FBEV_A_EBS1 16'hff82
`define FBEV_A_EBS2 16'hff83
`define FBEV_A_WDT_CS 16'hffbe
`define FBEV_A_WDT_CNT 16'hffbf
`define FBEV_BIT_PGM 0
`define FBEV_BIT_ERASE 1
`define FBEV_BIT_PV 2
`define FBEV_BIT_ERS_VFY 3
`define FBEV_WDT_START 8'h36
`define FBEV_WDT_STOP 8'h50
`define FBEV_WDT_LOAD 8'hfe
`define FBEV_CLK_MHZ 25
`define FBEV_T_VRD_US 2
`define FBEV_T_EVS_US 4
`define FBEV_CYC_VRD (`FBEV_T_VRD_US * `FBEV_CLK_MHZ)
`define FBEV_CYC_EVS (`FBEV_T_EVS_US * `FBEV_CLK_MHZ)
`define FBEV_T_PGM_MS 1
`define FBEV_CYC_PGM_MAX (`FBEV_T_PGM_MS * 1000 * `FBEV_CLK_MHZ)
`define FBEV_PGM_TRIES 6
`define FBEV_ERASE_TRIES 602
`define FBEV_T_ERASE_S 30
`define FBEV_R_CTRL 4'h0
`define FBEV_R_EBS1 4'h1
`define FBEV_R_EBS2 4'h2
`define FBEV_R_START 4'h3
`define FBEV_R_END 4'h4
`define FBEV_R_PGM_CYC 4'h5
`define FBEV_R_ERS_CYC 4'h6
`define FBEV_R_STATUS 4'h7
`define FBEV_R_ECOUNT 4'h8
`define FBEV_R_FAILADR 4'h9
`endif

// ===== design/fbev_bus_port.v
// Byte bus master toward the flash device: one access per request.
// Assumes the device answers reads combinationally in the access cycle.
`timescale 1ns/1ps
`include "fbev_defs.vh"
module fbev_bus_port (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire req_in,
	input wire req_wr_in,
	input wire [15:0] req_addr_in,
	input wire [7:0] req_data_in,
	input wire [7:0] dev_rdata_in,
	output reg done_out,
	output reg [7:0] rdata_out,
	output reg [15:0] dev_addr_out,
	output reg [7:0] dev_wdata_out,
	output reg dev_wr_out,
	output reg dev_rd_out
);
	reg [7:0] rsync1_ff;
	reg [7:0] rsync2_ff;
	reg [1:0] ph_ff;
	// Device read data is from another domain, so it is synchronised.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rsync1_ff <= 8'h00;
			rsync2_ff <= 8'h00;
			ph_ff <= 2'h0;
			done_out <= 1'b0;
			rdata_out <= 8'h00;
			dev_addr_out <= 16'h0000;
			dev_wdata_out <= 8'h00;
			dev_wr_out <= 1'b0;
			dev_rd_out <= 1'b0;
		end else begin
			rsync1_ff <= dev_rdata_in;
			rsync2_ff <= rsync1_ff;
			done_out <= 1'b0;
			case (ph_ff)
			2'h0: begin
				if (req_in) begin
					dev_addr_out <= req_addr_in;
					dev_wdata_out <= req_data_in;
					dev_wr_out <= req_wr_in;
					dev_rd_out <= ~req_wr_in;
					ph_ff <= 2'h1;
				end
			end
			2'h1: begin
				dev_wr_out <= 1'b0;
				ph_ff <= 2'h2;
			end
			2'h2: begin
				ph_ff <= 2'h3;
			end
			default: begin
				dev_rd_out <= 1'b0;
				rdata_out <= rsync2_ff;
				done_out <= 1'b1;
				ph_ff <= 2'h0;
			end
			endcase
		end
	end
endmodule

// ===== design/fbev_host.v
// Host sequencer that prewrites, erases and erase-verifies flash blocks.
// Assumes a byte bus to the device registers and array, one clock domain.
`timescale 1ns/1ps
`include "fbev_defs.vh"
module fbev_host (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire [3:0] sw_addr_in,
	input wire [15:0] sw_wdata_in,
	input wire sw_wr_in,
	input wire sw_rd_in,
	output reg [15:0] sw_rdata_out,
	input wire [7:0] dev_rdata_in,
	output wire [15:0] dev_addr_out,
	output wire [7:0] dev_wdata_out,
	output wire dev_wr_out,
	output wire dev_rd_out,
	output reg busy_out
);
	localparam [15:0] S_IDLE = 16'h0001;
	localparam [15:0] S_SEL1 = 16'h0002;
	localparam [15:0] S_SEL2 = 16'h0004;
	localparam [15:0] S_PW_DW = 16'h0008;
	localparam [15:0] S_PW_ON = 16'h0010;
	localparam [15:0] S_PW_OFF = 16'h0020;
	localparam [15:0] S_PW_PV = 16'h0040;
	localparam [15:0] S_PW_RD = 16'h0080;
	localparam [15:0] S_WD_ON = 16'h0100;
	localparam [15:0] S_ER_ON = 16'h0200;
	localparam [15:0] S_ER_OFF = 16'h0400;
	localparam [15:0] S_VF_ON = 16'h0800;
	localparam [15:0] S_VF_DW = 16'h1000;
	localparam [15:0] S_VF_RD = 16'h2000;
	localparam [15:0] S_VF_OFF = 16'h4000;
	localparam [15:0] S_END = 16'h8000;
	// Counts are worked out as integers and trimmed to register width here.
	localparam integer CYC_VRD_I = `FBEV_CYC_VRD;
	localparam integer CYC_EVS_I = `FBEV_CYC_EVS;
	localparam integer CYC_PMAX_I = `FBEV_CYC_PGM_MAX;
	localparam integer ETRIES_I = `FBEV_ERASE_TRIES;
	localparam integer PTRIES_I = `FBEV_PGM_TRIES;
	localparam [23:0] CYC_VRD = CYC_VRD_I[23:0];
	localparam [23:0] CYC_EVS = CYC_EVS_I[23:0];
	localparam [23:0] CYC_PMAX = CYC_PMAX_I[23:0];
	localparam [9:0] ETRIES = ETRIES_I[9:0];
	localparam [2:0] PTRIES = PTRIES_I[2:0];

	reg [7:0] ebs1_ff;
	reg [7:0] ebs2_ff;
	reg [15:0] start_ff;
	reg [15:0] end_ff;
	reg [23:0] pgm_cyc_ff;
	reg [23:0] ers_cyc_ff;
	reg [15:0] st_ff;
	reg [15:0] adr_ff;
	reg [23:0] tmr_ff;
	reg [23:0] pulse_ff;
	reg [23:0] ptot_ff;
	reg [2:0] ptry_ff;
	reg [9:0] etry_ff;
	reg vfy_fail_ff;
	reg ok_ff;
	reg err_ff;
	reg [15:0] fail_adr_ff;
	reg started_ff;
	reg [7:0] mode_ff;
	reg req_ff;
	reg req_wr_ff;
	reg [15:0] req_addr_ff;
	reg [7:0] req_data_ff;
	reg issued_ff;
	wire done;
	wire [7:0] rdata;
	wire tmr_zero;
	wire go;

	assign tmr_zero = (tmr_ff == 24'h00_0000);
	assign go = sw_wr_in && (sw_addr_in == `FBEV_R_CTRL) && sw_wdata_in[0];

	fbev_bus_port u_port (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.req_in(req_ff),
		.req_wr_in(req_wr_ff),
		.req_addr_in(req_addr_ff),
		.req_data_in(req_data_ff),
		.dev_rdata_in(dev_rdata_in),
		.done_out(done),
		.rdata_out(rdata),
		.dev_addr_out(dev_addr_out),
		.dev_wdata_out(dev_wdata_out),
		.dev_wr_out(dev_wr_out),
		.dev_rd_out(dev_rd_out)
	);

	// Software register port; reads answer one cycle after the strobe.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ebs1_ff <= 8'h00;
			ebs2_ff <= 8'h00;
			start_ff <= 16'h0000;
			end_ff <= 16'h0000;
			pgm_cyc_ff <= 24'h00_0019;
			ers_cyc_ff <= 24'h00_0064;
			sw_rdata_out <= 16'h0000;
		end else begin
			if (sw_wr_in && !busy_out) begin
				case (sw_addr_in)
				`FBEV_R_EBS1: ebs1_ff <= sw_wdata_in[7:0];
				`FBEV_R_EBS2: ebs2_ff <= sw_wdata_in[7:0];
				`FBEV_R_START: start_ff <= sw_wdata_in;
				`FBEV_R_END: end_ff <= sw_wdata_in;
				`FBEV_R_PGM_CYC: pgm_cyc_ff <= {8'h00, sw_wdata_in};
				`FBEV_R_ERS_CYC: ers_cyc_ff <= {8'h00, sw_wdata_in};
				default: ;
				endcase
			end
			sw_rdata_out <= 16'h0000;
			if (sw_rd_in) begin
				case (sw_addr_in)
				`FBEV_R_EBS1: sw_rdata_out <= {8'h00, ebs1_ff};
				`FBEV_R_EBS2: sw_rdata_out <= {8'h00, ebs2_ff};
				`FBEV_R_START: sw_rdata_out <= start_ff;
				`FBEV_R_END: sw_rdata_out <= end_ff;
				`FBEV_R_PGM_CYC: sw_rdata_out <= pgm_cyc_ff[15:0];
				`FBEV_R_ERS_CYC: sw_rdata_out <= ers_cyc_ff[15:0];
				`FBEV_R_STATUS: sw_rdata_out <= {13'h0000, err_ff, ok_ff,
					busy_out};
				`FBEV_R_ECOUNT: sw_rdata_out <= {6'h00, etry_ff};
				`FBEV_R_FAILADR: sw_rdata_out <= fail_adr_ff;
				default: sw_rdata_out <= 16'h0000;
				endcase
			end
		end
	end

	// Main sequencer: each state but S_IDLE issues one device access, then moves on.
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= S_IDLE;
			adr_ff <= 16'h0000;
			tmr_ff <= 24'h00_0000;
			pulse_ff <= 24'h00_0000;
			ptot_ff <= 24'h00_0000;
			ptry_ff <= 3'h0;
			etry_ff <= 10'h000;
			vfy_fail_ff <= 1'b0;
			ok_ff <= 1'b0;
			err_ff <= 1'b0;
			fail_adr_ff <= 16'h0000;
			mode_ff <= 8'h00;
			req_ff <= 1'b0;
			req_wr_ff <= 1'b0;
			req_addr_ff <= 16'h0000;
			req_data_ff <= 8'h00;
			issued_ff <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			req_ff <= 1'b0;
			if (!tmr_zero)
				tmr_ff <= tmr_ff - 24'h00_0001;
			if (done)
				issued_ff <= 1'b0;
			case (st_ff)
			S_IDLE: begin
				busy_out <= 1'b0;
				if (go) begin
					busy_out <= 1'b1;
					ok_ff <= 1'b0;
					err_ff <= 1'b0;
					etry_ff <= 10'h000;
					adr_ff <= start_ff;
					ptry_ff <= 3'h0;
					ptot_ff <= 24'h00_0000;
					pulse_ff <= pgm_cyc_ff;
					st_ff <= S_SEL1;
				end
			end
			S_SEL1, S_SEL2, S_PW_DW, S_PW_ON, S_PW_OFF, S_PW_PV, S_PW_RD,
			S_WD_ON, S_ER_ON, S_ER_OFF, S_VF_ON, S_VF_DW, S_VF_RD,
			S_VF_OFF, S_END: begin
				if (!issued_ff && !done && tmr_zero) begin
					issued_ff <= 1'b1;
					req_ff <= 1'b1;
					req_wr_ff <= 1'b1;
					req_data_ff <= mode_ff;
					req_addr_ff <= `FBEV_A_MODE;
					case (st_ff)
					S_SEL1: begin
						req_addr_ff <= `FBEV_A_EBS1;
						req_data_ff <= ebs1_ff; // RQ2
					end
					S_SEL2: begin
						req_addr_ff <= `FBEV_A_EBS2;
						req_data_ff <= ebs2_ff; // RQ2
					end
					S_PW_DW: begin
						req_addr_ff <= adr_ff;
						req_data_ff <= 8'h00; // RQ1
					end
					S_PW_ON: begin
						mode_ff[`FBEV_BIT_PGM] <= 1'b1;
						req_data_ff <= mode_ff | 8'h01;
					end
					S_PW_OFF: begin
						mode_ff[`FBEV_BIT_PGM] <= 1'b0;
						req_data_ff <= mode_ff & 8'hfe;
					end
					S_PW_PV: begin
						mode_ff[`FBEV_BIT_PV] <= 1'b1;
						req_data_ff <= mode_ff | 8'h04;
					end
					S_WD_ON: begin
						req_addr_ff <= `FBEV_A_WDT_CS;
						req_data_ff <= `FBEV_WDT_START; // RQ5
					end
					S_ER_ON: begin
						mode_ff[`FBEV_BIT_ERASE] <= 1'b1;
						req_data_ff <= 8'h02; // RQ3 RQ15
					end
					S_ER_OFF: begin
						mode_ff[`FBEV_BIT_ERASE] <= 1'b0;
						req_data_ff <= 8'h00; // RQ6 RQ15
					end
					S_VF_ON: begin
						mode_ff[`FBEV_BIT_ERS_VFY] <= 1'b1;
						req_data_ff <= 8'h08; // RQ6
					end
					S_VF_DW: begin
						req_addr_ff <= adr_ff;
						req_data_ff <= 8'hff; // RQ7 RQ8
					end
					S_PW_RD, S_VF_RD: begin
						req_wr_ff <= 1'b0;
						req_addr_ff <= adr_ff; // RQ8
					end
					S_VF_OFF, S_END: begin
						mode_ff <= 8'h00;
						req_data_ff <= 8'h00;
						if (st_ff == S_END)
							req_addr_ff <= `FBEV_A_WDT_CS;
						if (st_ff == S_END)
							req_data_ff <= `FBEV_WDT_STOP;
					end
					default: ;
					endcase
				end
				if (done) begin
					case (st_ff)
					S_SEL1: st_ff <= S_SEL2;
					S_SEL2: st_ff <= S_PW_DW;
					S_PW_DW: st_ff <= S_PW_ON;
					S_PW_ON: begin
						tmr_ff <= pulse_ff;
						ptot_ff <= ptot_ff + pulse_ff;
						ptry_ff <= ptry_ff + 3'h1;
						st_ff <= S_PW_OFF;
					end
					S_PW_OFF: st_ff <= S_PW_PV;
					S_PW_PV: begin
						tmr_ff <= CYC_EVS;
						st_ff <= S_PW_RD;
					end
					S_PW_RD: begin
						mode_ff <= 8'h00;
						if (rdata == 8'h00) begin
							ptry_ff <= 3'h0;
							ptot_ff <= 24'h00_0000;
							pulse_ff <= pgm_cyc_ff;
							if (adr_ff == end_ff) begin
								adr_ff <= start_ff;
								st_ff <= S_WD_ON;
							end else begin
								adr_ff <= adr_ff + 16'h0001;
								st_ff <= S_PW_DW;
							end
						end else if (ptry_ff == PTRIES ||
							ptot_ff + (pulse_ff << 1) > CYC_PMAX) begin
							err_ff <= 1'b1; // RQ14
							fail_adr_ff <= adr_ff;
							st_ff <= S_END;
						end else begin
							pulse_ff <= pulse_ff << 1;
							st_ff <= S_PW_DW;
						end
					end
					S_WD_ON: begin
						etry_ff <= etry_ff + 10'h001;
						vfy_fail_ff <= 1'b0;
						st_ff <= S_ER_ON;
					end
					S_ER_ON: begin
						tmr_ff <= ers_cyc_ff; // RQ4
						st_ff <= S_ER_OFF;
					end
					S_ER_OFF: st_ff <= S_VF_ON;
					S_VF_ON: begin
						tmr_ff <= CYC_EVS; // RQ10
						st_ff <= S_VF_DW;
					end
					S_VF_DW: begin
						tmr_ff <= CYC_VRD; // RQ9
						st_ff <= S_VF_RD;
					end
					S_VF_RD: begin
						if (rdata != 8'hff) begin
							vfy_fail_ff <= 1'b1; // RQ12
							fail_adr_ff <= adr_ff;
						end
						if (adr_ff == end_ff) begin
							st_ff <= S_VF_OFF;
						end else begin
							adr_ff <= adr_ff + 16'h0001; // RQ11
							st_ff <= S_VF_DW;
						end
					end
					S_VF_OFF: begin
						adr_ff <= start_ff;
						if (!vfy_fail_ff) begin
							ok_ff <= 1'b1;
							st_ff <= S_END;
						end else if (etry_ff == ETRIES) begin
							err_ff <= 1'b1; // RQ13
							st_ff <= S_END;
						end else begin
							st_ff <= S_WD_ON; // RQ12
						end
					end
					S_END: st_ff <= S_IDLE;
					default: st_ff <= S_IDLE;
					endcase
				end
			end
			default: st_ff <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== dv/fbev_host_properties.sv
// Checker for the flash erase host, bound to its top module.
// Assumes mode register at ff80 and watchdog control at ffbe.
`timescale 1ns/1ps
module fbev_host_properties (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] sw_addr_in,
	input wire logic [15:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	input wire logic [15:0] sw_rdata_out,
	input wire logic [7:0] dev_rdata_in,
	input wire logic [15:0] dev_addr_out,
	input wire logic [7:0] dev_wdata_out,
	input wire logic dev_wr_out,
	input wire logic dev_rd_out,
	input wire logic busy_out
);
	logic [7:0] mode_ff;
	logic [15:0] wa_ff;
	logic [7:0] wd_ff;
	logic [7:0] ad_ff;
	logic [15:0] gap_ff;
	wire mode_wr = dev_wr_out && dev_addr_out == 16'hff80;
	wire arr_wr = dev_wr_out && dev_addr_out < 16'hff00;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Tracks the last writes and the cycles since the last write.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mode_ff <= 8'h00;
			wa_ff <= 16'h0000;
			wd_ff <= 8'h00;
			ad_ff <= 8'h00;
			gap_ff <= 16'h0000;
		end else begin
			if (dev_wr_out) begin
				wa_ff <= dev_addr_out;
				wd_ff <= dev_wdata_out;
				gap_ff <= 16'h0000;
			end else if (gap_ff != 16'hffff) begin
				gap_ff <= gap_ff + 16'h0001;
			end
			if (mode_wr) begin
				mode_ff <= dev_wdata_out;
			end
			if (arr_wr) begin
				ad_ff <= dev_wdata_out;
			end
		end
	end
	sequence s_vread;
		$rose(dev_rd_out) && dev_addr_out < 16'hff00 && mode_ff == 8'h08;
	endsequence
	sequence s_rd3;
		dev_rd_out [*3] ##1 !dev_rd_out;
	endsequence
	a_prewrite_zero: assert property (mode_wr
		&& dev_wdata_out == 8'h01 |-> ad_ff == 8'h00)
		else $error("program started on nonzero data");
	a_erase_length: assert property (mode_wr && mode_ff == 8'h02
		&& dev_wdata_out == 8'h00 |-> gap_ff >= 16'h0063
		&& gap_ff <= 16'h006e)
		else $error("erase pulse length wrong");
	a_watchdog_first: assert property (mode_wr && dev_wdata_out == 8'h02
		|-> wa_ff == 16'hffbe && wd_ff == 8'h36)
		else $error("erase without watchdog start");
	a_verify_order: assert property (mode_wr && dev_wdata_out == 8'h08
		|-> wa_ff == 16'hff80 && mode_ff == 8'h00)
		else $error("verify set before erase cleared");
	a_dummy_write: assert property (s_vread
		|-> wa_ff == dev_addr_out && wd_ff == 8'hff)
		else $error("verify read without dummy write");
	a_read_gap: assert property (s_vread |-> gap_ff >= 16'h0031)
		else $error("verify read too early");
	a_first_dummy: assert property (arr_wr && mode_ff == 8'h08
		&& wa_ff == 16'hff80 |-> gap_ff >= 16'h0063)
		else $error("first dummy write too early");
	a_read_three: assert property ($rose(dev_rd_out) |-> s_rd3)
		else $error("device read not three cycles");
endmodule
bind fbev_host fbev_host_properties fbev_host_properties_inst (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
	.sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
	.dev_rdata_in(dev_rdata_in), .dev_addr_out(dev_addr_out),
	.dev_wdata_out(dev_wdata_out), .dev_wr_out(dev_wr_out),
	.dev_rd_out(dev_rd_out), .busy_out(busy_out));

// ===== dv/fbev_dev_model.sv
// Behavioural flash device with a 16 byte array and mode registers.
// Assumes the host samples read data while its read strobe is high.
`timescale 1ns/1ps
module fbev_dev_model #(
	parameter int ERASE_NEED = 150
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] dev_addr_in,
	input wire logic [7:0] dev_wdata_in,
	input wire logic dev_wr_in,
	input wire logic dev_rd_in,
	output logic [7:0] dev_rdata_out
);
	logic [7:0] mem [0:15];
	logic [7:0] mode_ff, ebs1_ff, ebs2_ff, wdt_ff, ldata_ff, val;
	logic [3:0] latch_ff;
	int prog_need = 40;
	int pcnt, ecnt;
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mode_ff <= 8'h00;
			ebs1_ff <= 8'h00;
			ebs2_ff <= 8'h00;
			wdt_ff <= 8'h00;
			pcnt <= 0;
			ecnt <= 0;
		end else begin
			if (dev_wr_in) begin
				case (dev_addr_in)
					16'hff80: mode_ff <= dev_wdata_in;
					16'hff82: ebs1_ff <= dev_wdata_in;
					16'hff83: ebs2_ff <= dev_wdata_in;
					16'hffbe: wdt_ff <= dev_wdata_in;
					default: begin
						if (latch_ff != dev_addr_in[3:0]) pcnt <= 0;
						latch_ff <= dev_addr_in[3:0];
						ldata_ff <= dev_wdata_in;
					end
				endcase
			end
			if (mode_ff[0] && !mode_ff[3]) begin
				pcnt <= pcnt + 1;
				if (pcnt + 1 >= prog_need) mem[latch_ff] <= ldata_ff;
			end
			// Erase acts only while the bit is held and verify is off.
			if (mode_ff[1] && !mode_ff[3]
				&& (ebs1_ff | ebs2_ff) != 0) begin
				ecnt <= ecnt + 1;
				if (ecnt + 1 >= ERASE_NEED) begin
					for (int i = 0; i < 16; i++) mem[i] <= 8'hff;
					ecnt <= 0;
				end
			end
		end
	end
	always_comb begin
		case (dev_addr_in)
			16'hff80: val = mode_ff;
			16'hff82: val = ebs1_ff;
			16'hff83: val = ebs2_ff;
			16'hffbe: val = wdt_ff;
			default: val = (mode_ff[2] | mode_ff[3]) ? mem[latch_ff]
				: mem[dev_addr_in[3:0]];
		endcase
	end
	// An idle bus shows the inverse so stale data cannot pass.
	assign dev_rdata_out = dev_rd_in ? val : ~val;
endmodule

// ===== dv/fbev_host_tb_top.sv
// Testbench for the flash erase host with a device model beside it.
// Assumes a 25 MHz clock and the software register map of the host.
`timescale 1ns/1ps
module fbev_host_tb_top;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [3:0] sw_addr_in = 4'h0;
	logic [15:0] sw_wdata_in = 16'h0000;
	logic sw_wr_in = 1'b0;
	logic sw_rd_in = 1'b0;
	wire [15:0] sw_rdata_out, dev_addr;
	wire [7:0] dev_rdata, dev_wdata;
	wire dev_wr, dev_rd, busy_out;
	int fails = 0;
	int checks_done = 0;
	always #20 core_clk_in = ~core_clk_in;
	fbev_host fbev_host_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
		.sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
		.dev_rdata_in(dev_rdata), .dev_addr_out(dev_addr),
		.dev_wdata_out(dev_wdata), .dev_wr_out(dev_wr), .dev_rd_out(dev_rd),
		.busy_out(busy_out));
	fbev_dev_model fbev_dev_model_inst (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .dev_addr_in(dev_addr), .dev_wdata_in(dev_wdata),
		.dev_wr_in(dev_wr), .dev_rd_in(dev_rd), .dev_rdata_out(dev_rdata));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		sw_addr_in <= a;
		sw_wdata_in <= d;
		sw_wr_in <= 1'b1;
		@(posedge core_clk_in);
		sw_wr_in <= 1'b0;
		@(posedge core_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		sw_addr_in <= a;
		sw_rd_in <= 1'b1;
		@(posedge core_clk_in);
		sw_rd_in <= 1'b0;
		#1 chk(sw_rdata_out, exp);
		@(posedge core_clk_in);
	endtask
	task automatic start;
		wr(4'h0, 16'h0001);
		chk({15'h0000, busy_out}, 16'h0001);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy_out !== 1'b0 && n < 10000) begin
			@(posedge core_clk_in);
			n++;
		end
		chk({15'h0000, busy_out}, 16'h0000);
	endtask
	task automatic final_report;
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#1200000;
		fails++;
		final_report();
	end
	initial begin
		for (int i = 0; i < 16; i++) fbev_dev_model_inst.mem[i] = 8'h5a;
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		rd(4'h5, 16'h0019);
		rd(4'h6, 16'h0064);
		rd(4'h7, 16'h0000);
		rd(4'hf, 16'h0000);
		wr(4'h1, 16'h0001);
		wr(4'h2, 16'h0000);
		wr(4'h3, 16'h0002);
		wr(4'h4, 16'h0005);
		rd(4'h1, 16'h0001);
		rd(4'h2, 16'h0000);
		rd(4'h3, 16'h0002);
		rd(4'h4, 16'h0005);
		start();
		wr(4'h6, 16'h0005);
		wait_idle();
		rd(4'h7, 16'h0002);
		rd(4'h8, 16'h0002);
		rd(4'h6, 16'h0064);
		chk({8'h00, fbev_dev_model_inst.ebs1_ff}, 16'h0001);
		chk({8'h00, fbev_dev_model_inst.ebs2_ff}, 16'h0000);
		for (int i = 2; i < 6; i++)
			chk({8'h00, fbev_dev_model_inst.mem[i]}, 16'h00ff);
		fbev_dev_model_inst.prog_need = 1000;
		wr(4'h5, 16'h0001);
		start();
		wait_idle();
		rd(4'h7, 16'h0004);
		rd(4'h9, 16'h0002);
		fbev_dev_model_inst.prog_need = 40;
		start();
		repeat (30) @(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		#1 chk({15'h0000, busy_out}, 16'h0000);
		@(posedge core_clk_in);
		rd(4'h7, 16'h0000);
		final_report();
	end
endmodule
